// ---- common/eeprom_params.svh ----
// Constants for the serial EEPROM command engine
// Behaviour
// - Write is start, write-direction select, acked address byte, then data bytes.
// - Programming starts only on stop in the slot right after a data acknowledge.
// - A stop in any other slot never starts programming.
// - While programming, data line stays released and all bus activity is ignored.
// - After programming, address counter points one past the last modified byte.
// - Write protect high: data bytes not acknowledged, memory left unchanged. Ident page data bytes are still acked and written.
// - Multi-byte write stays within one page; overflow wraps to page start.
// - Address counter advances after every accepted page write data byte; refused bytes and lock requests leave it.
// - Ident page write: type 1011b, A7 zero, low four bits pick the byte.
// - Locked ident page: every write data byte refused, page unchanged.
// - Lock request: type 1011b, A7 one, data bit 1 set, rest ignored.
// - Select byte refused while programming, acknowledged once programming ends.
// - Reads work whatever the write protect level.
// - Random read: write select, address, repeated start, read select, data.
// - Read select without address sends byte at counter, then increments it.
// - Bytes keep coming while master acks; no-ack plus stop ends stream.
// - Sequential memory read wraps from last address to 00h.
// - Ident page read: type 1011b, A7 zero; master stays within 16 bytes.
// - Lock query: one ident data byte acked if unlocked, refused if locked.
// - A start mid-instruction resets sequencing and drops the pending command.
// - Ident page has 16 bytes; bytes 0 to 2 hold factory codes.
// - Ident page access loads the shared address counter with the byte location.
// - Select bit 0 is direction; bits 3 to 1 are top memory address bits.
// - Unmatched type identifier: no acknowledge, release, standby until next start.
// - Write protect high: select and address bytes still acknowledged.
// - Master no-ack in ninth read slot ends sending, device goes standby.
`ifndef EEPROM_PARAMS_SVH
`define EEPROM_PARAMS_SVH

// Select byte type identifiers
`define TYPE_MEMORY 4'ha
`define TYPE_IDENT 4'hb

// Field positions
`define SEL_DIR_BIT 0
`define ADDR_LOCK_BIT 7
`define LOCK_DATA_BIT 1

// Array sizes
`define MEM_ADDR_W 11
`define MEM_BYTES 2048
`define PAGE_BYTES 16

// Factory ident codes, values arbitrary
`define IDENT_MAKER 8'h5a
`define IDENT_FAMILY 8'h3c
`define IDENT_DENSITY 8'h11

// Programming interval
`define CLOCK_PERIOD_NS 100
`define INTERNAL_PROGRAM_TIME_NS 5000
`define PROG_CNT_W 16
`define PROGRAM_CYCLES ((`INTERNAL_PROGRAM_TIME_NS + `CLOCK_PERIOD_NS - 1) / `CLOCK_PERIOD_NS)

`endif

// ---- common/eeprom_pkg.sv ----
// Types for the serial EEPROM command engine
package eeprom_pkg;

	// Link side sequencer states
	typedef enum logic [3:0] {
		ST_IDLE = 4'h0,
		ST_SELECT = 4'h1,
		ST_SEL_ACK = 4'h2,
		ST_ADDR = 4'h3,
		ST_ADDR_ACK = 4'h4,
		ST_WDATA = 4'h5,
		ST_WDATA_ACK = 4'h6,
		ST_RDATA = 4'h7,
		ST_RACK = 4'h8,
		ST_RNEXT = 4'h9,
		ST_BUSY = 4'ha
	} link_state_e;

	typedef logic [7:0] byte_t;

endpackage

// ---- src/bit_sync.sv ----
// Two flip-flop level synchroniser
`timescale 1ns/1ps
module bit_sync (
	// Clock
	input wire logic clk_in,
	// Level from another domain
	input wire logic d_in,
	// Synchronised level
	output logic q_out
);

	logic meta_reg;
	logic sync_reg;

	// First stage feeds only the second
	always_ff @(posedge clk_in) begin
		meta_reg <= d_in;
		sync_reg <= meta_reg;
	end

	assign q_out = sync_reg;

endmodule

// ---- src/eeprom_engine.sv ----
// Two-wire serial EEPROM slave: command sequencer, arrays and write cycle timer
`timescale 1ns/1ps
`include "eeprom_params.svh"
module eeprom_engine (
	// System clock and reset
	input wire logic clock_in,
	input wire logic srst_in,
	// Link sampling clock
	input wire logic link_clk_in,
	// Serial bus pins
	input wire logic scl_in,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe_out,
	// Write protect pin
	input wire logic write_protect_input_in,
	// Write cycle in progress
	output logic busy_out
);
	import eeprom_pkg::*;

	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------

	// Counter step: ident page wraps in 16, memory over the full array
	function automatic logic [`MEM_ADDR_W-1:0] read_step(input logic [`MEM_ADDR_W-1:0] a,
		input logic ident);
		read_step = ident ? {7'h00, a[3:0] + 4'h1} : a + 11'h001;
	endfunction

	// Write step stays inside the page
	function automatic logic [`MEM_ADDR_W-1:0] page_step(input logic [`MEM_ADDR_W-1:0] a);
		page_step = {a[10:4], a[3:0] + 4'h1};
	endfunction

	// ------------------------------------------------------------
	// Pin synchronisers, link domain
	// ------------------------------------------------------------
	logic scl_s;
	logic sda_s;
	logic wp_s;
	logic link_rst;
	logic done_tog_s;
	logic req_tog_s;

	bit_sync u_scl (.clk_in(link_clk_in), .d_in(scl_in), .q_out(scl_s));
	bit_sync u_sda (.clk_in(link_clk_in), .d_in(sda_in), .q_out(sda_s));
	bit_sync u_wp (.clk_in(link_clk_in), .d_in(write_protect_input_in), .q_out(wp_s));
	bit_sync u_rst (.clk_in(link_clk_in), .d_in(srst_in), .q_out(link_rst));

	// ------------------------------------------------------------
	// Storage
	// ------------------------------------------------------------
	byte_t mem [0:`MEM_BYTES-1];
	// Ident page starts with the factory codes, the rest erased
	byte_t ident_mem [0:`PAGE_BYTES-1] = '{0: `IDENT_MAKER, 1: `IDENT_FAMILY,
		2: `IDENT_DENSITY, default: 8'hff};
	logic lock_reg = 1'b0;

	// ------------------------------------------------------------
	// Link side sequencer
	// ------------------------------------------------------------
	link_state_e state_reg, state_next;
	logic [3:0] bit_cnt_reg, bit_cnt_next;
	byte_t shift_reg, shift_next;
	logic oe_reg, oe_next;
	logic [`MEM_ADDR_W-1:0] addr_reg, addr_next;
	logic ident_reg, ident_next;
	logic lock_sel_reg, lock_sel_next;
	logic [2:0] sel_hi_reg, sel_hi_next;
	logic armed_reg, armed_next;
	byte_t buf_reg [0:`PAGE_BYTES-1];
	byte_t buf_next [0:`PAGE_BYTES-1];
	logic [`PAGE_BYTES-1:0] valid_reg, valid_next;
	logic lock_req_reg, lock_req_next;
	logic [6:0] page_reg, page_next;
	logic req_tog_reg, req_tog_next;
	logic scl_q_reg;
	logic sda_q_reg;
	logic done_q_reg;
	logic sda_zero_reg;

	logic start_det;
	logic stop_det;
	logic scl_rise;
	logic scl_fall;
	logic done_edge;
	logic commit;
	byte_t rd_byte;

	// Bus events from synchronised pins
	assign start_det = scl_s & scl_q_reg & sda_q_reg & ~sda_s;
	assign stop_det = scl_s & scl_q_reg & ~sda_q_reg & sda_s;
	assign scl_rise = scl_s & ~scl_q_reg;
	assign scl_fall = ~scl_s & scl_q_reg;
	assign done_edge = done_tog_s ^ done_q_reg;

	// Byte at the shared counter
	assign rd_byte = ident_reg ? ident_mem[addr_reg[3:0]] : mem[addr_reg];

	// Next state of the sequencer
	always_comb begin
		state_next = state_reg;
		bit_cnt_next = bit_cnt_reg;
		shift_next = shift_reg;
		oe_next = oe_reg;
		addr_next = addr_reg;
		ident_next = ident_reg;
		lock_sel_next = lock_sel_reg;
		sel_hi_next = sel_hi_reg;
		armed_next = armed_reg;
		buf_next = buf_reg;
		valid_next = valid_reg;
		lock_req_next = lock_req_reg;
		page_next = page_reg;
		req_tog_next = req_tog_reg;
		commit = 1'b0;
		if (state_reg == ST_BUSY) begin
			// Deaf and released until the write cycle ends
			oe_next = 1'b0;
			if (done_edge) begin
				commit = 1'b1;
				state_next = ST_IDLE;
			end
		end else if (start_det) begin
			// Restart sequencing, drop anything pending
			state_next = ST_SELECT;
			bit_cnt_next = 4'h0;
			oe_next = 1'b0;
			armed_next = 1'b0;
			valid_next = '0;
			lock_req_next = 1'b0;
		end else if (stop_det) begin
			oe_next = 1'b0;
			if (state_reg == ST_WDATA && armed_reg && (valid_reg != '0 || lock_req_reg)) begin
				state_next = ST_BUSY;
				req_tog_next = ~req_tog_reg;
			end else begin
				state_next = ST_IDLE;
			end
		end else begin
			unique case (state_reg)
				ST_SELECT, ST_ADDR, ST_WDATA: begin
					if (scl_rise && bit_cnt_reg != 4'h8) begin
						// Sample on rising clock, first bit is msb; stop may follow first rise
						shift_next = {shift_reg[6:0], sda_s};
						bit_cnt_next = bit_cnt_reg + 4'h1;
						armed_next = armed_reg && bit_cnt_reg == 4'h0;
					end else if (scl_fall && bit_cnt_reg == 4'h8) begin
						if (state_reg == ST_SELECT) begin
							if (shift_reg[7:4] == `TYPE_MEMORY || shift_reg[7:4] == `TYPE_IDENT) begin
								ident_next = (shift_reg[7:4] == `TYPE_IDENT);
								sel_hi_next = shift_reg[3:1];
								lock_sel_next = shift_reg[`SEL_DIR_BIT];
								oe_next = 1'b1;
								state_next = ST_SEL_ACK;
							end else begin
								state_next = ST_IDLE;
							end
						end else if (state_reg == ST_ADDR) begin
							lock_sel_next = shift_reg[`ADDR_LOCK_BIT];
							addr_next = ident_reg ? {7'h00, shift_reg[3:0]}
								: {sel_hi_reg, shift_reg};
							page_next = {sel_hi_reg, shift_reg[7:4]};
							oe_next = 1'b1;
							state_next = ST_ADDR_ACK;
						end else begin
							if (ident_reg && lock_sel_reg) begin
								// Lock request
								oe_next = ~lock_reg;
								if (!lock_reg && shift_reg[`LOCK_DATA_BIT]) begin
									lock_req_next = 1'b1;
								end
							end else if (ident_reg) begin
								oe_next = ~lock_reg;
								if (!lock_reg) begin
									buf_next[addr_reg[3:0]] = shift_reg;
									valid_next[addr_reg[3:0]] = 1'b1;
									addr_next = page_step(addr_reg);
								end
							end else begin
								oe_next = ~wp_s;
								if (!wp_s) begin
									buf_next[addr_reg[3:0]] = shift_reg;
									valid_next[addr_reg[3:0]] = 1'b1;
									addr_next = page_step(addr_reg);
								end
							end
							state_next = ST_WDATA_ACK;
						end
					end
				end
				ST_SEL_ACK: begin
					if (scl_fall) begin
						bit_cnt_next = 4'h0;
						if (lock_sel_reg) begin
							// Read direction: first bit goes out now
							lock_sel_next = 1'b0;
							shift_next = {rd_byte[6:0], 1'b0};
							oe_next = ~rd_byte[7];
							bit_cnt_next = 4'h1;
							state_next = ST_RDATA;
						end else begin
							oe_next = 1'b0;
							state_next = ST_ADDR;
						end
					end
				end
				ST_ADDR_ACK: begin
					if (scl_fall) begin
						oe_next = 1'b0;
						bit_cnt_next = 4'h0;
						state_next = ST_WDATA;
					end
				end
				ST_WDATA_ACK: begin
					if (scl_fall) begin
						// Next slot is the one where stop launches programming
						oe_next = 1'b0;
						bit_cnt_next = 4'h0;
						armed_next = 1'b1;
						state_next = ST_WDATA;
					end
				end
				ST_RDATA: begin
					if (scl_fall) begin
						if (bit_cnt_reg == 4'h8) begin
							oe_next = 1'b0;
							addr_next = read_step(addr_reg, ident_reg);
							state_next = ST_RACK;
						end else begin
							oe_next = ~shift_reg[7];
							shift_next = {shift_reg[6:0], 1'b0};
							bit_cnt_next = bit_cnt_reg + 4'h1;
						end
					end
				end
				ST_RACK: begin
					if (scl_rise) begin
						state_next = sda_s ? ST_IDLE : ST_RNEXT;
					end
				end
				ST_RNEXT: begin
					if (scl_fall) begin
						shift_next = {rd_byte[6:0], 1'b0};
						oe_next = ~rd_byte[7];
						bit_cnt_next = 4'h1;
						state_next = ST_RDATA;
					end
				end
				ST_IDLE, ST_BUSY: begin
					oe_next = 1'b0;
				end
			endcase
		end
	end

	// Sequencer registers
	always_ff @(posedge link_clk_in) begin
		scl_q_reg <= scl_s;
		sda_q_reg <= sda_s;
		done_q_reg <= done_tog_s;
		sda_zero_reg <= 1'b0;
		buf_reg <= buf_next;
		if (link_rst) begin
			state_reg <= ST_IDLE;
			bit_cnt_reg <= 4'h0;
			shift_reg <= 8'h00;
			oe_reg <= 1'b0;
			addr_reg <= 11'h000;
			ident_reg <= 1'b0;
			lock_sel_reg <= 1'b0;
			sel_hi_reg <= 3'h0;
			armed_reg <= 1'b0;
			valid_reg <= '0;
			lock_req_reg <= 1'b0;
			page_reg <= 7'h00;
			req_tog_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			bit_cnt_reg <= bit_cnt_next;
			shift_reg <= shift_next;
			oe_reg <= oe_next;
			addr_reg <= addr_next;
			ident_reg <= ident_next;
			lock_sel_reg <= lock_sel_next;
			sel_hi_reg <= sel_hi_next;
			armed_reg <= armed_next;
			valid_reg <= valid_next;
			lock_req_reg <= lock_req_next;
			page_reg <= page_next;
			req_tog_reg <= req_tog_next;
		end
	end

	// Commit of the page buffer; lock flag is never cleared
	always_ff @(posedge link_clk_in) begin
		if (commit) begin
			for (int i = 0; i < `PAGE_BYTES; i++) begin
				if (valid_reg[i]) begin
					if (ident_reg) begin
						ident_mem[i] <= buf_reg[i];
					end else begin
						mem[{page_reg, 4'(i)}] <= buf_reg[i];
					end
				end
			end
			if (lock_req_reg) begin
				lock_reg <= 1'b1;
			end
		end
	end

	// Open-drain data pin only ever pulls low
	assign sda_out = sda_zero_reg;
	assign sda_oe_out = oe_reg;

	// ------------------------------------------------------------
	// Write cycle timer, system domain
	// ------------------------------------------------------------
	logic req_q_reg, req_q_next;
	logic done_tog_reg, done_tog_next;
	logic busy_reg, busy_next;
	logic [`PROG_CNT_W-1:0] cnt_reg, cnt_next;

	bit_sync u_req (.clk_in(clock_in), .d_in(req_tog_reg), .q_out(req_tog_s));
	bit_sync u_done (.clk_in(link_clk_in), .d_in(done_tog_reg), .q_out(done_tog_s));

	// Count the programming interval, then hand back a done toggle
	always_comb begin
		req_q_next = req_tog_s;
		done_tog_next = done_tog_reg;
		busy_next = busy_reg;
		cnt_next = cnt_reg;
		if (req_tog_s != req_q_reg) begin
			busy_next = 1'b1;
			cnt_next = `PROG_CNT_W'(`PROGRAM_CYCLES);
		end else if (busy_reg) begin
			if (cnt_reg == `PROG_CNT_W'(1)) begin
				busy_next = 1'b0;
				done_tog_next = ~done_tog_reg;
			end
			cnt_next = cnt_reg - `PROG_CNT_W'(1);
		end
	end

	// Timer registers
	always_ff @(posedge clock_in) begin
		if (srst_in) begin
			req_q_reg <= 1'b0;
			done_tog_reg <= 1'b0;
			busy_reg <= 1'b0;
			cnt_reg <= '0;
		end else begin
			req_q_reg <= req_q_next;
			done_tog_reg <= done_tog_next;
			busy_reg <= busy_next;
			cnt_reg <= cnt_next;
		end
	end

	assign busy_out = busy_reg;

endmodule

// ---- verif/eeprom_engine_chk.sv ----
// Port checks on the serial EEPROM command engine
`timescale 1ns/1ps
`include "eeprom_params.svh"
module eeprom_engine_chk (
	// Clocks and reset
	input wire logic clock_in,
	input wire logic srst_in,
	input wire logic link_clk_in,
	// Serial pins
	input wire logic scl_in,
	input wire logic sda_in,
	input wire logic sda_out,
	input wire logic sda_oe_out,
	// Control and status
	input wire logic write_protect_input_in,
	input wire logic busy_out
);
	logic [15:0] busy_cnt_reg;
	logic [15:0] busy_cnt_next;
	// Length of the running busy interval
	always_comb begin
		busy_cnt_next = busy_out ? busy_cnt_reg + 16'h1 : 16'h0;
	end
	always_ff @(posedge clock_in) begin
		busy_cnt_reg <= srst_in ? 16'h0 : busy_cnt_next;
	end
	// ----
	// Checks
	// ----
	chk_sda_low: assert property (@(posedge clock_in) disable iff (srst_in)
		sda_out == 1'b0) else $error("sda driven high");
	chk_busy_quiet: assert property (@(posedge clock_in) disable iff (srst_in)
		busy_out |-> !sda_oe_out) else $error("line pulled while busy");
	chk_busy_len: assert property (@(posedge clock_in) disable iff (srst_in)
		$fell(busy_out) |-> busy_cnt_reg == 16'(`PROGRAM_CYCLES)) else $error("busy length");
	chk_busy_end: assert property (@(posedge clock_in) disable iff (srst_in)
		$rose(busy_out) |-> ##50 $fell(busy_out)) else $error("busy not ended");
	chk_busy_idle: assert property (@(posedge clock_in) disable iff (srst_in)
		$rose(busy_out) |-> scl_in && sda_in) else $error("busy without stop");
	chk_busy_gap: assert property (@(posedge clock_in) disable iff (srst_in)
		$fell(busy_out) |=> !busy_out [*8]) else $error("busy restarted");
	chk_ack_rise: assert property (@(posedge link_clk_in) disable iff (srst_in)
		$rose(sda_oe_out) |-> !scl_in) else $error("pull began with scl high");
	chk_ack_fall: assert property (@(posedge link_clk_in) disable iff (srst_in)
		$fell(sda_oe_out) |-> !scl_in) else $error("release with scl high");
	chk_ack_hold: assert property (@(posedge link_clk_in) disable iff (srst_in)
		sda_oe_out && scl_in |=> sda_oe_out) else $error("pull dropped early");
	cover property (@(posedge clock_in) $rose(busy_out));
	cover property (@(posedge link_clk_in) $rose(sda_oe_out));
	cover property (@(posedge link_clk_in) sda_oe_out && write_protect_input_in);
endmodule

bind eeprom_engine eeprom_engine_chk i_chk (.clock_in(clock_in), .srst_in(srst_in),
	.link_clk_in(link_clk_in), .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out),
	.sda_oe_out(sda_oe_out), .write_protect_input_in(write_protect_input_in),
	.busy_out(busy_out));

// ---- verif/i2c_master_model.sv ----
// Behavioural two-wire bus master for the engine's serial pins
`timescale 1ns/1ps
module i2c_master_model (
	// Pacing clock
	input wire logic clk_in,
	// Resolved data line
	input wire logic sda_in,
	// Serial clock and data pull-down
	output logic scl_out,
	output logic sda_oe_out
);
	// Bus idle: clock high, line released
	initial begin
		scl_out = 1'b1;
		sda_oe_out = 1'b0;
	end
	// Quarter bit slot
	task automatic q();
		repeat (3) @(negedge clk_in);
	endtask
	// One bit slot, line sampled mid high phase
	task automatic bit_x(input logic b, output logic s);
		scl_out = 1'b0;
		q();
		sda_oe_out = !b;
		q();
		scl_out = 1'b1;
		q();
		s = sda_in;
		q();
	endtask
	// ----
	// Conditions and bytes
	// ----
	task automatic start();
		scl_out = 1'b0;
		q();
		sda_oe_out = 1'b0;
		q();
		scl_out = 1'b1;
		q();
		sda_oe_out = 1'b1;
		q();
	endtask
	// Stop, then idle long enough to settle
	task automatic stop();
		scl_out = 1'b0;
		q();
		sda_oe_out = 1'b1;
		q();
		scl_out = 1'b1;
		q();
		sda_oe_out = 1'b0;
		repeat (3) q();
	endtask
	task automatic wr_byte(input logic [7:0] d, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--) bit_x(d[i], s);
		bit_x(1'b1, s);
		ack = !s;
	endtask
	task automatic rd_byte(input logic ack, output logic [7:0] d);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			bit_x(1'b1, s);
			d[i] = s;
		end
		bit_x(!ack, s);
	endtask
endmodule

// ---- verif/tb_serial_eeprom_command_engine.sv ----
// Self-checking bench for the serial EEPROM command engine
`timescale 1ns/1ps
`include "eeprom_params.svh"
`define CHK(n, e, g) begin samples_checked++; if ((e) !== (g)) begin \
	$display("FAIL %s exp %h got %h", n, e, g); bad_count++; end end
module tb_serial_eeprom_command_engine;
	logic clock_in = 1'b0;
	logic link_clk_in = 1'b0;
	logic srst_in = 1'b1;
	logic write_protect = 1'b0;
	logic scl, m_oe, d_oe, d_out, busy, a;
	logic [7:0] r;
	logic [7:0] mem [int];
	int bad_count = 0;
	int samples_checked = 0;
	// Pulled-up data line
	wire sda = !(m_oe || (d_oe && !d_out));
	always #50 clock_in = !clock_in;
	initial #7 forever #32 link_clk_in = !link_clk_in;
	eeprom_engine i_dut (.clock_in(clock_in), .srst_in(srst_in), .link_clk_in(link_clk_in),
		.scl_in(scl), .sda_in(sda), .sda_out(d_out), .sda_oe_out(d_oe),
		.write_protect_input_in(write_protect), .busy_out(busy));
	i2c_master_model i_mst (.clk_in(clock_in), .sda_in(sda), .scl_out(scl), .sda_oe_out(m_oe));
	// ----
	// Bus helpers
	// ----
	task automatic rst();
		@(negedge clock_in) srst_in = 1'b1;
		repeat (5) @(negedge clock_in);
		srst_in = 1'b0;
		repeat (3) @(negedge clock_in);
	endtask
	task automatic sel(input logic [7:0] s, input logic e);
		i_mst.start();
		i_mst.wr_byte(s, a);
		`CHK("select ack", e, a)
	endtask
	// Poll through the programming interval
	task automatic prog(input logic [7:0] s);
		for (int i = 0; i < 20 && !busy; i++) @(negedge clock_in);
		`CHK("busy", 1'b1, busy)
		sel(s, 1'b0);
		i_mst.stop();
		`CHK("busy", 1'b0, busy)
		sel(s, 1'b1);
		i_mst.stop();
	endtask
	task automatic wr(input logic [3:0] t, input logic [10:0] ad, input int n,
		input logic [7:0] d0, input logic e);
		sel({t, ad[10:8], 1'b0}, 1'b1);
		i_mst.wr_byte(ad[7:0], a);
		`CHK("addr ack", 1'b1, a)
		for (int i = 0; i < n; i++) begin
			i_mst.wr_byte(d0 + 8'(i), a);
			`CHK("data ack", e, a)
			if (e && t == `TYPE_MEMORY) mem[{ad[10:4], 4'(ad[3:0] + i)}] = d0 + 8'(i);
		end
		i_mst.stop();
		if (e) prog({t, ad[10:8], 1'b0});
		else `CHK("no cycle", 1'b0, busy)
	endtask
	task automatic cur(input logic [3:0] t, input logic [2:0] h, input logic [7:0] x[$]);
		sel({t, h, 1'b1}, 1'b1);
		foreach (x[i]) begin
			i_mst.rd_byte(i < x.size() - 1, r);
			`CHK("read data", x[i], r)
		end
		i_mst.stop();
	endtask
	task automatic rd(input logic [3:0] t, input logic [10:0] ad, input logic [7:0] x[$]);
		sel({t, ad[10:8], 1'b0}, 1'b1);
		i_mst.wr_byte(ad[7:0], a);
		cur(t, ad[10:8], x);
	endtask
	task automatic query(input logic e);
		sel({`TYPE_IDENT, 4'h0}, 1'b1);
		i_mst.wr_byte(8'h0f, a);
		i_mst.wr_byte(8'h5e, a);
		`CHK("lock state", e, a)
		i_mst.start();
		i_mst.stop();
		`CHK("no cycle", 1'b0, busy)
	endtask
	// ----
	// Scenarios
	// ----
	task automatic t_page();
		logic [7:0] x[$];
		wr(`TYPE_MEMORY, 11'h1fe, 17, 8'h40, 1'b1);
		cur(`TYPE_MEMORY, 3'h1, '{mem[32'h1ff]});
		for (int i = 0; i < 16; i++) x.push_back(mem[32'h1f0 + i]);
		rd(`TYPE_MEMORY, 11'h1f0, x);
	endtask
	task automatic t_wp();
		write_protect = 1'b1;
		wr(`TYPE_MEMORY, 11'h1f5, 1, 8'h99, 1'b0);
		rd(`TYPE_MEMORY, 11'h1f5, '{mem[32'h1f5]});
		write_protect = 1'b0;
	endtask
	task automatic t_wrap();
		wr(`TYPE_MEMORY, 11'h7ff, 1, 8'hc3, 1'b1);
		wr(`TYPE_MEMORY, 11'h000, 1, 8'h3c, 1'b1);
		rd(`TYPE_MEMORY, 11'h7ff, '{8'hc3, 8'h3c});
	endtask
	task automatic t_ident();
		sel(8'h90, 1'b0);
		i_mst.stop();
		rd(`TYPE_IDENT, 11'h000, '{`IDENT_MAKER, `IDENT_FAMILY, `IDENT_DENSITY});
		wr(`TYPE_IDENT, 11'h035, 1, 8'h77, 1'b1);
		rd(`TYPE_IDENT, 11'h005, '{8'h77});
		query(1'b1);
		wr(`TYPE_IDENT, 11'h080, 1, 8'h02, 1'b1);
		query(1'b0);
		wr(`TYPE_IDENT, 11'h005, 1, 8'h11, 1'b0);
		rst();
		query(1'b0);
		rd(`TYPE_IDENT, 11'h005, '{8'h77});
	endtask
	task automatic give_verdict();
		$display("comparisons %0d mismatches %0d", samples_checked, bad_count);
		if (bad_count == 0 && samples_checked > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	// Main sequence
	initial begin
		rst();
		t_page();
		t_wp();
		t_wrap();
		t_ident();
		give_verdict();
	end
	// Watchdog
	initial begin
		#3000000;
		bad_count++;
		give_verdict();
	end
endmodule
